// ==== hw/brc_defs.svh ====
/*
 * offsets, field positions, reset values and masks of the bridge
 * interrupt and control register bank.
 * assumes inclusion by bare name from the bank's design files.
 */
`ifndef BRC_DEFS_SVH
`define BRC_DEFS_SVH

// ----------------------------------------------------------------
// register indexes, byte address is four times the index
// ----------------------------------------------------------------
`define BRC_IDX_IRQ_LINE 8'h3C
`define BRC_IDX_IRQ_PIN 8'h3D
`define BRC_IDX_BR_CTL 8'h3E
`define BRC_IDX_SYS_CTL 8'h20
`define BRC_IDX_STATUS 8'h21
`define BRC_FN_SEL_BIT 10

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define BRC_IRQ_LINE_RST 8'hFF
`define BRC_BR_CTL_RST 16'h0340
`define BRC_CTL_SOCK_MASK 16'h07CC
`define BRC_CTL_SHARED_WR_MASK 16'h0022
`define BRC_CTL_PERR_RO_VAL 1'b0
`define BRC_PIN_INTA 8'h01
`define BRC_PIN_INTB 8'h02
`define BRC_MODE_RST 2'h3

// ----------------------------------------------------------------
// bridge control bit positions
// ----------------------------------------------------------------
`define BRC_B_POST 10
`define BRC_B_PF1 9
`define BRC_B_PF0 8
`define BRC_B_ROUTE 7
`define BRC_B_CARD_BUS_RESET_OUT 6
`define BRC_B_MABT 5
`define BRC_B_VGA 3
`define BRC_B_ISA 2
`define BRC_B_CSERR 1
`define BRC_B_CPERR 0

// ----------------------------------------------------------------
// own system control bit positions
// ----------------------------------------------------------------
`define BRC_S_TIE 29
`define BRC_S_MFT3 2
`define BRC_S_MODE_LO 0

// ----------------------------------------------------------------
// address windows for forwarding decode
// ----------------------------------------------------------------
`define BRC_ISA_TOP 32'h0000FFFF
`define BRC_VGA_MEM_LO 32'h000A0000
`define BRC_VGA_MEM_HI 32'h000BFFFF
`define BRC_VGA_IO_A_LO 32'h000003B0
`define BRC_VGA_IO_A_HI 32'h000003BB
`define BRC_VGA_IO_B_LO 32'h000003C0
`define BRC_VGA_IO_B_HI 32'h000003DF

`endif

// ==== hw/brc_pkg.sv ====
/*
 * types of the bridge interrupt and control register bank.
 * assumes nothing beyond a systemverilog compiler.
 */
package brc_pkg;

   // four interrupt signaling modes, serialized both is the default
   typedef enum logic [1:0]
   {
      BRC_MODE_PAR_PCI = 2'b00,
      BRC_MODE_PAR_BOTH = 2'b01,
      BRC_MODE_SER_IRQ = 2'b10,
      BRC_MODE_SER_ALL = 2'b11
   } brc_irq_mode_t;

   typedef logic [1:0] brc_sock_t;

   typedef logic [15:0] brc_ctl_t;

endpackage

// ==== hw/brc_func_regs.sv ====
/*
 * per-function storage: routing byte and the socket dependent
 * bridge control bits of one function.
 * assumes write strobes already decoded and gated by the bus slave.
 */
`timescale 1ns/1ps
`include "brc_defs.svh"

module brc_func_regs
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic line_we_i,
   input wire logic ctl_we_i,
   input wire logic [1:0] sel_i,
   input wire logic [15:0] wdat_i,
   output logic [7:0] line_o,
   output brc_pkg::brc_ctl_t ctl_o
);
   import brc_pkg::*;

   logic [7:0] line_q;
   logic [7:0] line_d;
   brc_ctl_t ctl_q;
   brc_ctl_t ctl_d;
   wire [15:0] lane_mask;
   wire [15:0] wr_mask;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   // reserved and shared bits never land in this copy
   assign wr_mask = lane_mask & `BRC_CTL_SOCK_MASK;

   always_comb
   begin
      line_d = line_q;
      ctl_d = ctl_q;
      if (line_we_i && sel_i[0])
      begin
         line_d = wdat_i[7:0];
      end
      if (ctl_we_i)
      begin
         ctl_d = (ctl_q & ~wr_mask) | (wdat_i & wr_mask);
      end
   end

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         line_q <= `BRC_IRQ_LINE_RST;
         ctl_q <= `BRC_BR_CTL_RST & `BRC_CTL_SOCK_MASK;
      end
      else
      begin
         line_q <= line_d;
         ctl_q <= ctl_d;
      end
   end

   assign line_o = line_q;
   assign ctl_o = ctl_q;

endmodule

// ==== hw/brc_top.sv ====
/*
 * bridge interrupt and control register bank for two socket
 * functions, reached over a classic wishbone slave, plus the
 * socket side effects these registers steer.
 * assumes one 20 mhz clock, card side inputs synchronous to it,
 * and an asynchronous active low host reset on nrst_i.
 */
// Added by the designer: the Wishbone slave port.
// Overview of operation
// - each function keeps a read/write routing byte, resets to FFh
// - with interrupt tie set both functions report pin 01h
// - tie clear: function 0 reports 01h, function 1 reports 02h
// - bridge control resets to 0340h; bits 15-11 and 4 read zero
// - bit 10 enables burst write posting, one copy per function
// - bits 9 and 8 mark windows 1 and 0 prefetchable, reset one
// - bit 7 routes card interrupts to pci lines or legacy irq
// - bit 6 drives card reset, asserted at reset and by host reset
// - shared bit 5: report card master abort as target abort, serr
// - bit 3 set forwards vga addresses to the card bus
// - bit 2 set blocks last 768 bytes of each 1k isa io block
// - shared bit 1 forwards card system error to host serr
// - shared bit 0, read only, gates card parity error reporting
// - interrupt tie merges both requests onto the first pci line
`timescale 1ns/1ps
`include "brc_defs.svh"

module brc_top
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] card_irq_i,
   output logic pci_inta_o,
   output logic pci_intb_o,
   output logic [1:0] legacy_irq_req_o,
   output logic [1:0] card_bus_reset_out_o,
   output logic [1:0] write_post_enable_o,
   output logic [1:0] window0_prefetchable_o,
   output logic [1:0] window1_prefetchable_o,
   input wire logic [31:0] fwd_addr_i,
   input wire logic fwd_is_io_i,
   output logic [1:0] vga_claim_o,
   output logic [1:0] isa_block_o,
   input wire logic [1:0] card_master_abort_i,
   input wire logic serr_enable_i,
   output logic target_abort_o,
   output logic host_serr_o,
   input wire logic [1:0] card_syserr_i,
   input wire logic [1:0] card_parity_err_i,
   output logic [1:0] card_parity_report_o,
   output logic multifunction_terminal_three_serial_o,
   output brc_pkg::brc_irq_mode_t irq_mode_o
);
   import brc_pkg::*;

   // ----------------------------------------------------------------
   // forwarding decode helpers
   // ----------------------------------------------------------------
   function automatic logic in_range(input logic [31:0] a,
      input logic [31:0] lo, input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic is_vga(input logic [31:0] a,
      input logic io);
      if (io)
      begin
         is_vga = in_range(a, `BRC_VGA_IO_A_LO, `BRC_VGA_IO_A_HI) ||
            in_range(a, `BRC_VGA_IO_B_LO, `BRC_VGA_IO_B_HI);
      end
      else
      begin
         is_vga = in_range(a, `BRC_VGA_MEM_LO, `BRC_VGA_MEM_HI);
      end
   endfunction

   // upper three quarters of every 1k block below 64k
   function automatic logic is_isa_alias(input logic [31:0] a,
      input logic io);
      is_isa_alias = io && (a <= `BRC_ISA_TOP) && (a[9:8] != 2'h0);
   endfunction

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic ack_q;
   logic [31:0] rdat_q;
   wire req;
   wire wr_commit;
   wire fn_sel;
   wire [7:0] idx;
   wire hit_line;
   wire hit_pin;
   wire hit_ctl;
   wire hit_sys;
   wire hit_stat;

   assign req = wb_cyc_i && wb_stb_i;
   // a write lands on the edge where the master sees ack
   assign wr_commit = req && wb_we_i && ack_q;
   assign fn_sel = wb_adr_i[`BRC_FN_SEL_BIT];
   assign idx = wb_adr_i[9:2];
   assign hit_line = (idx == `BRC_IDX_IRQ_LINE);
   assign hit_pin = (idx == `BRC_IDX_IRQ_PIN);
   assign hit_ctl = (idx == `BRC_IDX_BR_CTL);
   assign hit_sys = (idx == `BRC_IDX_SYS_CTL);
   assign hit_stat = (idx == `BRC_IDX_STATUS);

   // ----------------------------------------------------------------
   // per function copies
   // ----------------------------------------------------------------
   logic [7:0] line_v [2];
   brc_ctl_t sock_ctl [2];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_fn
         wire fn_hit;
         assign fn_hit = wr_commit && (fn_sel == 1'(g));
         brc_func_regs u_regs
         (
            .mclk_i(mclk_i),
            .nrst_i(nrst_i),
            .line_we_i(fn_hit && hit_line),
            .ctl_we_i(fn_hit && hit_ctl),
            .sel_i(wb_sel_i[1:0]),
            .wdat_i(wb_dat_i[15:0]),
            .line_o(line_v[g]),
            .ctl_o(sock_ctl[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // shared control bits and own system control
   // ----------------------------------------------------------------
   brc_ctl_t shared_q;
   brc_ctl_t shared_d;
   logic tie_q;
   logic tie_d;
   logic mft3_q;
   logic mft3_d;
   brc_irq_mode_t mode_q;
   brc_irq_mode_t mode_d;
   wire [15:0] sh_mask;

   // a write through either function reaches the single shared copy;
   // keeping to function 0 is left to software
   assign sh_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} &
      `BRC_CTL_SHARED_WR_MASK;

   always_comb
   begin
      shared_d = shared_q;
      tie_d = tie_q;
      mft3_d = mft3_q;
      mode_d = mode_q;
      if (wr_commit && hit_ctl)
      begin
         shared_d = (shared_q & ~sh_mask) | (wb_dat_i[15:0] & sh_mask);
      end
      if (wr_commit && hit_sys && wb_sel_i[3])
      begin
         tie_d = wb_dat_i[`BRC_S_TIE];
      end
      if (wr_commit && hit_sys && wb_sel_i[0])
      begin
         mft3_d = wb_dat_i[`BRC_S_MFT3];
         mode_d = brc_irq_mode_t'(wb_dat_i[`BRC_S_MODE_LO +: 2]);
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         shared_q <= '0;
         tie_q <= 1'b0;
         mft3_q <= 1'b0;
         mode_q <= brc_irq_mode_t'(`BRC_MODE_RST);
      end
      else
      begin
         shared_q <= shared_d;
         tie_q <= tie_d;
         mft3_q <= mft3_d;
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------------------------------
   // read view
   // ----------------------------------------------------------------
   brc_ctl_t ctl_view [2];
   wire [7:0] pin_view [2];
   wire [31:0] sys_view;
   wire [31:0] stat_view;
   wire [31:0] rd_mux;
   wire fs;

   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_view
         // parity bit reads its fixed value, writes never reach it
         assign ctl_view[g] = sock_ctl[g] | shared_q |
            {15'h0000, `BRC_CTL_PERR_RO_VAL};
         // pin report ignores the signaling mode
         assign pin_view[g] = (tie_q || g == 0) ? `BRC_PIN_INTA :
            `BRC_PIN_INTB;
      end
   endgenerate

   assign sys_view = {2'h0, tie_q, 26'h0000000, mft3_q, mode_q};
   assign stat_view = {24'h000000, legacy_irq_req_o, pci_intb_o,
      pci_inta_o, 2'h0, card_bus_reset_out_o};
   assign fs = fn_sel;
   // unmapped indexes answer with zero data
   assign rd_mux = hit_line ? {24'h000000, line_v[fs]} :
      hit_pin ? {24'h000000, pin_view[fs]} :
      hit_ctl ? {16'h0000, ctl_view[fs]} :
      hit_sys ? sys_view :
      hit_stat ? stat_view : 32'h00000000;

   // ----------------------------------------------------------------
   // wishbone answer, one cycle after the request
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ack_q <= 1'b0;
         rdat_q <= '0;
      end
      else
      begin
         ack_q <= req && !ack_q;
         if (req && !ack_q)
         begin
            rdat_q <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------------------------------
   // socket side effects
   // ----------------------------------------------------------------
   logic inta_q;
   logic intb_q;
   logic [1:0] legacy_q;
   logic [1:0] vga_q;
   logic [1:0] isa_q;
   logic tabort_q;
   logic serr_q;
   logic [1:0] perr_q;
   wire [1:0] to_pci;
   wire [1:0] to_legacy;
   wire [1:0] vga_d;
   wire [1:0] isa_d;
   wire [1:0] mabt_rep;
   wire [1:0] syserr_fwd;
   wire [1:0] perr_d;

   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_sock
         assign to_legacy[g] = card_irq_i[g] &&
            sock_ctl[g][`BRC_B_ROUTE];
         assign to_pci[g] = card_irq_i[g] &&
            !sock_ctl[g][`BRC_B_ROUTE];
         assign vga_d[g] = sock_ctl[g][`BRC_B_VGA] &&
            is_vga(fwd_addr_i, fwd_is_io_i);
         assign isa_d[g] = sock_ctl[g][`BRC_B_ISA] &&
            is_isa_alias(fwd_addr_i, fwd_is_io_i);
         assign mabt_rep[g] = card_master_abort_i[g] &&
            shared_q[`BRC_B_MABT];
         assign syserr_fwd[g] = card_syserr_i[g] &&
            shared_q[`BRC_B_CSERR];
         assign perr_d[g] = card_parity_err_i[g] &&
            ctl_view[g][`BRC_B_CPERR];
         assign card_bus_reset_out_o[g] =
            sock_ctl[g][`BRC_B_CARD_BUS_RESET_OUT];
         assign write_post_enable_o[g] =
            sock_ctl[g][`BRC_B_POST];
         assign window0_prefetchable_o[g] =
            sock_ctl[g][`BRC_B_PF0];
         assign window1_prefetchable_o[g] =
            sock_ctl[g][`BRC_B_PF1];
      end
   endgenerate

   // card reset bits reset to one, so a host reset asserts card reset
   // for as long as it is held and after it until software clears it

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         inta_q <= 1'b0;
         intb_q <= 1'b0;
         legacy_q <= '0;
         vga_q <= '0;
         isa_q <= '0;
         tabort_q <= 1'b0;
         serr_q <= 1'b0;
         perr_q <= '0;
      end
      else
      begin
         // tie folds function 1 onto the first line
         inta_q <= to_pci[0] || (tie_q && to_pci[1]);
         intb_q <= !tie_q && to_pci[1];
         legacy_q <= to_legacy;
         vga_q <= vga_d;
         isa_q <= isa_d;
         tabort_q <= |mabt_rep;
         serr_q <= ((|mabt_rep) && serr_enable_i) || (|syserr_fwd);
         perr_q <= perr_d;
      end
   end

   assign pci_inta_o = inta_q;
   assign pci_intb_o = intb_q;
   assign legacy_irq_req_o = legacy_q;
   assign vga_claim_o = vga_q;
   assign isa_block_o = isa_q;
   assign target_abort_o = tabort_q;
   assign host_serr_o = serr_q;
   assign card_parity_report_o = perr_q;
   // terminal three must carry the serial stream before tie is set
   assign multifunction_terminal_three_serial_o = mft3_q;
   assign irq_mode_o = mode_q;

endmodule

// ==== bench/brc_monitor.sv ====
/*
 * port assertions for the bridge interrupt and control bank.
 * assumes binding into brc_top, one clock, async low reset.
 */
`timescale 1ns/1ps

module brc_monitor
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] card_irq_i,
   input wire logic pci_inta_o,
   input wire logic pci_intb_o,
   input wire logic [1:0] legacy_irq_req_o,
   input wire logic [1:0] card_bus_reset_out_o,
   input wire logic [1:0] write_post_enable_o,
   input wire logic [1:0] window0_prefetchable_o,
   input wire logic [1:0] window1_prefetchable_o,
   input wire logic [31:0] fwd_addr_i,
   input wire logic fwd_is_io_i,
   input wire logic [1:0] vga_claim_o,
   input wire logic [1:0] isa_block_o,
   input wire logic [1:0] card_master_abort_i,
   input wire logic serr_enable_i,
   input wire logic target_abort_o,
   input wire logic host_serr_o,
   input wire logic [1:0] card_syserr_i,
   input wire logic [1:0] card_parity_report_o
);
   // ---------------------------------------------
   // address decode seen by the forwarding checks
   // ---------------------------------------------
   wire logic vga_io = (fwd_addr_i >= 32'h3B0 && fwd_addr_i <= 32'h3BB) ||
      (fwd_addr_i >= 32'h3C0 && fwd_addr_i <= 32'h3DF);
   wire logic vga_mem = fwd_addr_i >= 32'hA0000 && fwd_addr_i <= 32'hBFFFF;
   wire logic vga_hit = fwd_is_io_i ? vga_io : vga_mem;
   wire logic isa_hit = fwd_is_io_i && fwd_addr_i <= 32'hFFFF &&
      fwd_addr_i[9:8] != 2'h0;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence one_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   bus_answer_a: assert property (wb_req |=> one_ack)
      else $error("ack is not one cycle after the request");
   card_reset_a: assert property ($rose(nrst_i) |->
      card_bus_reset_out_o == 2'h3) else $error("card reset not asserted");
   window_reset_a: assert property ($rose(nrst_i) |->
      window0_prefetchable_o == 2'h3 && window1_prefetchable_o == 2'h3 &&
      write_post_enable_o == 2'h0) else $error("window defaults wrong");
   inta_cause_a: assert property (pci_inta_o |->
      $past(card_irq_i) != 2'h0) else $error("inta without request");
   intb_cause_a: assert property (pci_intb_o |->
      $past(card_irq_i[1])) else $error("intb without request");
   route_excl_a: assert property (legacy_irq_req_o != 2'h0 |->
      (legacy_irq_req_o & ~$past(card_irq_i)) == 2'h0 &&
      !(legacy_irq_req_o[1] && pci_intb_o)) else $error("bad irq route");
   abort_cause_a: assert property (target_abort_o |->
      $past(card_master_abort_i) != 2'h0) else $error("stray target abort");
   serr_cause_a: assert property (host_serr_o |->
      $past(card_syserr_i) != 2'h0 || ($past(card_master_abort_i) != 2'h0
      && $past(serr_enable_i))) else $error("stray host serr");
   parity_quiet_a: assert property (card_parity_report_o == 2'h0)
      else $error("parity reported while response is read only zero");
   vga_claim_a: assert property (vga_claim_o != 2'h0 |->
      $past(vga_hit)) else $error("vga claim outside vga range");
   isa_block_a: assert property (isa_block_o != 2'h0 |->
      $past(isa_hit)) else $error("isa block outside filtered range");
endmodule

bind brc_top brc_monitor brc_monitor_inst (.mclk_i, .nrst_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .card_irq_i, .pci_inta_o, .pci_intb_o,
   .legacy_irq_req_o, .card_bus_reset_out_o, .write_post_enable_o,
   .window0_prefetchable_o, .window1_prefetchable_o, .fwd_addr_i,
   .fwd_is_io_i, .vga_claim_o, .isa_block_o, .card_master_abort_i,
   .serr_enable_i, .target_abort_o, .host_serr_o, .card_syserr_i,
   .card_parity_report_o);

// ==== bench/brc_card_model.sv ====
/*
 * behavioural card side of both sockets.
 * assumes request levels from the bench, synchronous to mclk_i.
 */
`timescale 1ns/1ps

module brc_card_model
(
   input wire logic mclk_i,
   input wire logic [1:0] card_bus_reset_out_i,
   input wire logic [1:0] irq_req_i,
   input wire logic [1:0] abort_req_i,
   input wire logic [1:0] syserr_req_i,
   input wire logic [1:0] perr_req_i,
   output logic [1:0] card_irq_o,
   output logic [1:0] card_master_abort_o,
   output logic [1:0] card_syserr_o,
   output logic [1:0] card_parity_err_o
);
   always_ff @(posedge mclk_i)
   begin
      // a card held in reset raises no interrupt; abort, system and parity errors pass through
      card_irq_o <= irq_req_i & ~card_bus_reset_out_i;
      card_master_abort_o <= abort_req_i;
      card_syserr_o <= syserr_req_i;
      card_parity_err_o <= perr_req_i;
   end
endmodule

// ==== bench/brc_top_tb_top.sv ====
/*
 * self-checking bench of the bridge interrupt and control bank.
 * assumes brc_top, brc_card_model and the bound checker.
 */
`timescale 1ns/1ps

module brc_top_tb_top;
   import brc_pkg::*;
   logic mclk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [11:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, fwd_addr_i;
   logic [1:0] card_irq_i, legacy_irq_req_o, card_bus_reset_out_o;
   logic [1:0] write_post_enable_o, window0_prefetchable_o;
   logic [1:0] window1_prefetchable_o, vga_claim_o, isa_block_o;
   logic [1:0] card_master_abort_i, card_syserr_i, card_parity_err_i;
   logic [1:0] card_parity_report_o, irq_req, abort_req, syserr_req, perr_req;
   logic pci_inta_o, pci_intb_o, fwd_is_io_i, serr_enable_i;
   logic target_abort_o, host_serr_o, multifunction_terminal_three_serial_o;
   brc_irq_mode_t irq_mode_o;
   int failures, checks;

   brc_top brc_top_inst (.mclk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .card_irq_i,
      .pci_inta_o, .pci_intb_o, .legacy_irq_req_o, .card_bus_reset_out_o,
      .write_post_enable_o, .window0_prefetchable_o, .window1_prefetchable_o,
      .fwd_addr_i, .fwd_is_io_i, .vga_claim_o, .isa_block_o,
      .card_master_abort_i, .serr_enable_i, .target_abort_o, .host_serr_o,
      .card_syserr_i, .card_parity_err_i, .card_parity_report_o,
      .multifunction_terminal_three_serial_o, .irq_mode_o);

   brc_card_model brc_card_model_inst (.mclk_i,
      .card_bus_reset_out_i(card_bus_reset_out_o), .irq_req_i(irq_req),
      .abort_req_i(abort_req), .syserr_req_i(syserr_req),
      .perr_req_i(perr_req), .card_irq_o(card_irq_i),
      .card_master_abort_o(card_master_abort_i),
      .card_syserr_o(card_syserr_i), .card_parity_err_o(card_parity_err_i));

   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   task chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // ------------------------------------------------
   // bus master: holds the request until ack is seen
   // ------------------------------------------------
   task wb(input logic we, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      // no cycle limit of its own, the watchdog ends a hung wait
      do
      begin
         @(posedge mclk_i);
      end
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, a, d, s, q);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hF, q);
      chk("rdata", q, e);
   endtask

   // outputs are registered, two edges cover cause plus flop
   task settle();
      repeat (2) @(posedge mclk_i);
      #1;
   endtask

   task pulse_abort();
      @(posedge mclk_i);
      abort_req <= 2'h1;
      @(posedge mclk_i);
      abort_req <= 2'h0;
      @(posedge mclk_i);
      #1;
   endtask

   task t_defaults();
      rd(12'h0F0, 32'hFF);
      rd(12'h4F0, 32'hFF);
      rd(12'h0F8, 32'h340);
      rd(12'h4F8, 32'h340);
      rd(12'h0F4, 32'h1);
      rd(12'h4F4, 32'h2);
      rd(12'h004, 32'h0);
      settle();
      chk("card_bus_reset_out", card_bus_reset_out_o, 32'h3);
      chk("win", {window1_prefetchable_o, window0_prefetchable_o,
         write_post_enable_o}, 32'h3C);
      $display("test defaults done");
   endtask

   task t_regs();
      wr(12'h0F0, 32'h5A, 4'h1);
      wr(12'h4F0, 32'hA5, 4'h1);
      rd(12'h0F0, 32'h5A);
      rd(12'h4F0, 32'hA5);
      wr(12'h4F8, 32'hFFDC, 4'h3);
      rd(12'h4F8, 32'h7CC);
      rd(12'h0F8, 32'h340);
      settle();
      chk("post", write_post_enable_o, 32'h2);
      wr(12'h0F8, 32'hFFFF, 4'h3);
      rd(12'h0F8, 32'h7EE);
      rd(12'h4F8, 32'h7EE);
      wr(12'h0F8, 32'h0, 4'h3);
      wr(12'h4F8, 32'h0, 4'h3);
      rd(12'h4F8, 32'h0);
      settle();
      chk("ctl", {card_bus_reset_out_o, window1_prefetchable_o,
         window0_prefetchable_o, write_post_enable_o}, 32'h0);
      $display("test regs done");
   endtask

   task t_pins();
      for (int m = 0; m < 4; m++)
      begin
         wr(12'h080, m, 4'h1);
         rd(12'h0F4, 32'h1);
         rd(12'h4F4, 32'h2);
         chk("mode", irq_mode_o, m);
      end
      // terminal three goes serial before the tie is set
      wr(12'h080, 32'h7, 4'h1);
      wr(12'h080, 32'h20000007, 4'h9);
      rd(12'h0F4, 32'h1);
      rd(12'h4F4, 32'h1);
      irq_req <= 2'h2;
      settle();
      chk("tie", {multifunction_terminal_three_serial_o, pci_inta_o,
         pci_intb_o}, 32'h6);
      wr(12'h080, 32'h7, 4'h9);
      settle();
      chk("untie", {pci_inta_o, pci_intb_o}, 32'h1);
      wr(12'h4F8, 32'h80, 4'h3);
      settle();
      chk("route", {legacy_irq_req_o, pci_intb_o}, 32'h4);
      @(posedge mclk_i);
      irq_req <= 2'h0;
      settle();
      chk("route", {legacy_irq_req_o, pci_intb_o}, 32'h0);
      wr(12'h4F8, 32'h0, 4'h3);
      $display("test pins done");
   endtask

   task t_errors();
      serr_enable_i <= 1'b1;
      pulse_abort();
      chk("abort", {target_abort_o, host_serr_o}, 32'h0);
      wr(12'h0F8, 32'h22, 4'h1);
      pulse_abort();
      chk("abort", {target_abort_o, host_serr_o}, 32'h3);
      @(posedge mclk_i);
      serr_enable_i <= 1'b0;
      pulse_abort();
      chk("abort", {target_abort_o, host_serr_o}, 32'h2);
      @(posedge mclk_i);
      syserr_req <= 2'h2;
      perr_req <= 2'h3;
      settle();
      chk("serr", {card_parity_report_o, host_serr_o}, 32'h1);
      wr(12'h0F8, 32'h0, 4'h1);
      settle();
      chk("serr", host_serr_o, 32'h0);
      @(posedge mclk_i);
      syserr_req <= 2'h0;
      perr_req <= 2'h0;
      $display("test errors done");
   endtask

   task fwd(input logic [31:0] a, input logic io, input logic [3:0] e);
      @(posedge mclk_i);
      fwd_addr_i <= a;
      fwd_is_io_i <= io;
      settle();
      chk("fwd", {vga_claim_o, isa_block_o}, e);
   endtask

   task t_fwd();
      // card reset was cleared earlier, a host reset must raise it again
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      settle();
      chk("card_bus_reset_out", card_bus_reset_out_o, 32'h3);
      wr(12'h0F8, 32'hC, 4'h1);
      fwd(32'hA0000, 1'b0, 4'h4);
      fwd(32'hC0000, 1'b0, 4'h0);
      fwd(32'h3C0, 1'b1, 4'h5);
      fwd(32'h100, 1'b1, 4'h1);
      fwd(32'h4FF, 1'b1, 4'h0);
      fwd(32'h10100, 1'b1, 4'h0);
      $display("test forwarding done");
   endtask

   task conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // generous bound, the whole run takes under three hundred cycles
   initial
   begin
      #2000000;
      failures++;
      conclude();
   end

   initial
   begin
      {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, fwd_is_io_i} = 5'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i, fwd_addr_i} = 80'h0;
      {irq_req, abort_req, syserr_req, perr_req} = 8'h0;
      serr_enable_i = 1'b0;
      failures = 0;
      checks = 0;
      repeat (4) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_defaults();
      t_regs();
      t_pins();
      t_errors();
      t_fwd();
      conclude();
   end
endmodule
